// file: src/adss_map.vh
// Timing constants and register map of the ADC strobe sequencer
`ifndef ADSS_MAP_VH
`define ADSS_MAP_VH

// ------------------------------------------------------------
// Clock and time figures
// ------------------------------------------------------------
`define ADSS_CLK_MHZ 250
`define ADSS_STB_LOW_US 5
`define ADSS_CUR_HIGH_US 5
`define ADSS_TMP_HIGH_US 10
`define ADSS_TMP_SETTLE_US 5
`define ADSS_TMP_ACQ_MIN_US 5
`define ADSS_GAP_US 5
`define ADSS_ACQ_FIXED 2
`define ADSS_DIV_MUL 4
`define ADSS_ADC_MAX_MHZ 10
`define ADSS_TURN_CYC 10

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ADSS_REG_CTRL 8'h00
`define ADSS_REG_CFG 8'h04
`define ADSS_REG_STAT 8'h08
`define ADSS_REG_RES 8'h0c

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define ADSS_CTRL_GO 0
`define ADSS_CTRL_TEMP 1
`define ADSS_CTRL_CH_LO 4
`define ADSS_CTRL_CH_HI 6
`define ADSS_CFG_STC_LO 0
`define ADSS_CFG_STC_HI 7
`define ADSS_CFG_DIV_LO 8
`define ADSS_CFG_DIV_HI 15
`define ADSS_CFG_RST 32'h0000_0000
`define ADSS_CH_NUM 8
`define ADSS_RESP_OK 2'b00
`define ADSS_RESP_ERR 2'b10

`endif

// file: src/adss_sequencer.v
// ADC strobe sequencer with AXI4-Lite register slave
// Operation
// - Each channel has own strobe, raised per conversion
// - Strobe stays low 5us after each fall
// - Current strobe held high at least 5us
// - Temperature strobe held high at least 10us
// - Temperature waits 5us settle before ADC start
// - Sample exact acquisition time, then start conversion
// - Temperature acquisition never below 5us
// - Strobe high whole channel time, drop on switch
// - Same channel not resampled within 5us gap
// - Conversion plus processing time at least 5us
// - Acquisition lasts two plus stc ADC clocks
// - ADC clock period four times one plus divider; dividers under 6 are raised to 6
// - Ten cycle turnaround before next conversion start
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "adss_map.vh"

module adss_sequencer (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire adc_done_i,
  input wire [11:0] adc_result_i,
  output reg [7:0] strobe_o,
  output reg adc_sample_o,
  output reg adc_start_o,
  output reg adc_clk_o,
  output reg busy_o
);

  // ------------------------------------------------------------
  // Derived cycle counts, rounded up
  // ------------------------------------------------------------
  localparam [31:0] CYC_LOW = `ADSS_STB_LOW_US * `ADSS_CLK_MHZ;
  localparam [31:0] CYC_CUR = `ADSS_CUR_HIGH_US * `ADSS_CLK_MHZ;
  localparam [31:0] CYC_TMP = `ADSS_TMP_HIGH_US * `ADSS_CLK_MHZ;
  localparam [31:0] CYC_SET = `ADSS_TMP_SETTLE_US * `ADSS_CLK_MHZ;
  localparam [31:0] CYC_ACQ = `ADSS_TMP_ACQ_MIN_US * `ADSS_CLK_MHZ;
  localparam [31:0] CYC_GAP = `ADSS_GAP_US * `ADSS_CLK_MHZ;
  // Smallest divider keeping the ADC clock at or under its ceiling
  localparam [31:0] DIV_MIN =
    (`ADSS_CLK_MHZ + `ADSS_DIV_MUL * `ADSS_ADC_MAX_MHZ - 1) /
    (`ADSS_DIV_MUL * `ADSS_ADC_MAX_MHZ) - 1;
  localparam [8:0] ACQ_FIX = `ADSS_ACQ_FIXED;

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_SETTLE = 3'd1;
  localparam [2:0] ST_SAMPLE = 3'd2;
  localparam [2:0] ST_CONV = 3'd3;
  localparam [2:0] ST_HOLD = 3'd4;
  localparam [2:0] ST_TURN = 3'd5;

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  reg [31:0] cfg_r;
  reg [2:0] ch_r;
  reg temp_r;
  reg go_r;
  reg [11:0] result_r;
  reg done_r;
  reg [2:0] st_r;
  reg [31:0] cnt_r;
  reg [31:0] hold_r;
  reg [9:0] div_cnt_r;
  reg adc_done_s1_r;
  reg adc_done_s2_r;
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;

  wire [7:0] stc = cfg_r[`ADSS_CFG_STC_HI:`ADSS_CFG_STC_LO];
  wire [7:0] div_raw = cfg_r[`ADSS_CFG_DIV_HI:`ADSS_CFG_DIV_LO];
  // Clamp divider so the ADC clock never exceeds its limit
  wire [7:0] div_set = (div_raw < DIV_MIN[7:0]) ? DIV_MIN[7:0] : div_raw;
  // Half ADC period in system clocks is 2*(1+div)
  wire [9:0] half_per = {1'b0, div_set, 1'b0} + 10'd2;
  wire [8:0] acq_len = {1'b0, stc} + ACQ_FIX;
  wire [10:0] per_len = {half_per, 1'b0}; // Full ADC period
  wire [31:0] smp_cyc = acq_len * per_len; // Window in system clocks

  // ------------------------------------------------------------
  // Per-channel low-time guard counters
  // ------------------------------------------------------------
  wire [`ADSS_CH_NUM-1:0] ch_ready;
  genvar gi;
  generate
    for (gi = 0; gi < `ADSS_CH_NUM; gi = gi + 1) begin : g_low
      reg [31:0] low_cnt_r;
      // Count from each falling edge; ready once the gap has passed
      always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          low_cnt_r <= 32'd0;
        end else if (strobe_o[gi]) begin
          low_cnt_r <= (CYC_LOW > CYC_GAP) ? CYC_LOW : CYC_GAP;
        end else if (low_cnt_r != 32'd0) begin
          low_cnt_r <= low_cnt_r - 32'd1;
        end
      end
      assign ch_ready[gi] = (low_cnt_r == 32'd0);
    end
  endgenerate

  // ------------------------------------------------------------
  // AXI4-Lite write path; address and data in either order
  // ------------------------------------------------------------
  wire wr_fire = aw_got_r && w_got_r && !s_axi_bvalid_o;
  wire wr_ctrl = wr_fire && (aw_addr_r[7:2] == `ADSS_REG_CTRL >> 2);
  wire wr_cfg = wr_fire && (aw_addr_r[7:2] == `ADSS_REG_CFG >> 2);
  wire wr_ok = wr_ctrl || wr_cfg;
  wire start_req = wr_ctrl && w_strb_r[0] && w_data_r[`ADSS_CTRL_GO];
  wire [2:0] req_ch = w_data_r[`ADSS_CTRL_CH_HI:`ADSS_CTRL_CH_LO];
  wire req_tmp = w_data_r[`ADSS_CTRL_TEMP];

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `ADSS_RESP_OK;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      s_axi_awready_o <= !aw_got_r && !s_axi_awready_o && s_axi_awvalid_i;
      s_axi_wready_o <= !w_got_r && !s_axi_wready_o && s_axi_wvalid_i;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? `ADSS_RESP_OK : `ADSS_RESP_ERR;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Configuration and control fields; byte lanes honoured
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_r <= `ADSS_CFG_RST;
      ch_r <= 3'd0;
      temp_r <= 1'b0;
    end else begin
      if (wr_cfg && w_strb_r[0]) begin
        cfg_r[7:0] <= w_data_r[7:0];
      end
      if (wr_cfg && w_strb_r[1]) begin
        cfg_r[15:8] <= w_data_r[15:8];
      end
      // Channel select is frozen while a conversion runs
      if (wr_ctrl && w_strb_r[0] && st_r == ST_IDLE) begin
        ch_r <= w_data_r[`ADSS_CTRL_CH_HI:`ADSS_CTRL_CH_LO];
        temp_r <= w_data_r[`ADSS_CTRL_TEMP];
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `ADSS_RESP_OK;
    end else begin
      s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o &&
        s_axi_arvalid_i;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= `ADSS_RESP_OK;
        case (s_axi_araddr_i)
          `ADSS_REG_CTRL: begin
            s_axi_rdata_o <= {25'd0, ch_r, 2'b00, temp_r, go_r};
          end
          `ADSS_REG_CFG: begin
            s_axi_rdata_o <= {16'd0, cfg_r[15:0]};
          end
          `ADSS_REG_STAT: begin
            s_axi_rdata_o <= {ch_ready, 19'd0, done_r, 1'b0, st_r};
          end
          `ADSS_REG_RES: begin
            s_axi_rdata_o <= {20'd0, result_r};
          end
          default: begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `ADSS_RESP_ERR;
          end
        endcase
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // ADC clock divider and done synchroniser
  // ------------------------------------------------------------
  // Free-running; the sampling window is timed in system clocks
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt_r <= 10'd0;
      adc_clk_o <= 1'b0;
      adc_done_s1_r <= 1'b0;
      adc_done_s2_r <= 1'b0;
    end else begin
      adc_done_s1_r <= adc_done_i;
      adc_done_s2_r <= adc_done_s1_r;
      if (div_cnt_r >= half_per - 10'd1) begin
        div_cnt_r <= 10'd0;
        adc_clk_o <= !adc_clk_o;
      end else begin
        div_cnt_r <= div_cnt_r + 10'd1;
      end
    end
  end

  // ------------------------------------------------------------
  // Sequence state machine
  // ------------------------------------------------------------
  // Strobe stays up through settle, sample, conversion and hold
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= ST_IDLE;
      cnt_r <= 32'd0;
      hold_r <= 32'd0;
      strobe_o <= 8'h00;
      adc_sample_o <= 1'b0;
      adc_start_o <= 1'b0;
      busy_o <= 1'b0;
      go_r <= 1'b0;
      done_r <= 1'b0;
      result_r <= 12'h000;
    end else begin
      adc_start_o <= 1'b0;
      if (hold_r != 32'd0) begin
        hold_r <= hold_r - 32'd1;
      end
      case (st_r)
        ST_IDLE: begin
          busy_o <= 1'b0;
          if (start_req) begin
            done_r <= 1'b0;
          end
          // A start inside the low time is dropped; fields come from the GO word, not copies
          if (start_req && ch_ready[req_ch]) begin
            go_r <= 1'b1;
            busy_o <= 1'b1;
            strobe_o <= 8'h01 << req_ch;
            hold_r <= req_tmp ? CYC_TMP : CYC_CUR;
            cnt_r <= req_tmp ? CYC_SET : smp_cyc;
            adc_sample_o <= !req_tmp;
            st_r <= req_tmp ? ST_SETTLE : ST_SAMPLE;
          end
        end
        ST_SETTLE: begin
          if (cnt_r <= 32'd1) begin
            // Temperature floor keeps acquisition at least 5us
            cnt_r <= (smp_cyc < CYC_ACQ) ? CYC_ACQ : smp_cyc;
            adc_sample_o <= 1'b1;
            st_r <= ST_SAMPLE;
          end else begin
            cnt_r <= cnt_r - 32'd1;
          end
        end
        ST_SAMPLE: begin
          // Window counted in system clocks, so its length is exact
          if (cnt_r <= 32'd1) begin
            adc_sample_o <= 1'b0;
            adc_start_o <= 1'b1;
            st_r <= ST_CONV;
          end else begin
            cnt_r <= cnt_r - 32'd1;
          end
        end
        ST_CONV: begin
          if (adc_done_s2_r) begin
            result_r <= adc_result_i;
            st_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Pad so strobe high time meets its floor
          if (hold_r == 32'd0) begin
            strobe_o <= 8'h00;
            cnt_r <= `ADSS_TURN_CYC;
            st_r <= ST_TURN;
          end
        end
        ST_TURN: begin
          if (cnt_r <= 32'd1) begin
            go_r <= 1'b0;
            done_r <= 1'b1;
            st_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 32'd1;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// file: sim/adss_adc_model.sv
// Behavioural ADC front end answering the sequencer's conversion starts
`timescale 1ns/1ps

module adss_adc_model #(
  parameter int CONV = 30
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic sample_i,
  input wire logic [11:0] val_i,
  output logic done_o,
  output logic [11:0] result_o
);
  int cnt;
  logic [11:0] last;

  // Done rises a fixed time after start, drops when the next sample opens
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 0;
      done_o <= 1'b0;
      last <= 12'h000;
    end else if (start_i) begin
      // Strobe timing is trusted as given, as in ADC-only use
      cnt <= CONV;
    end else if (cnt == 1) begin
      cnt <= 0;
      done_o <= 1'b1;
      last <= val_i;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (sample_i) begin
      done_o <= 1'b0;
    end
  end

  // Stale data is inverted so a late capture cannot pass by luck
  assign result_o = done_o ? last : ~last;
endmodule

// file: sim/adss_sequencer_chk.sv
// Port-level assertions for the ADC strobe sequencer
`timescale 1ns/1ps

module adss_sequencer_chk (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [7:0] strobe_o,
  input wire adc_sample_o,
  input wire adc_start_o,
  input wire adc_clk_o,
  input wire busy_o
);
  localparam int LO = 1250;
  localparam int HC = 1250;
  localparam int HT = 2500;
  int lo_cnt [8];
  int hi_cnt;
  int ck_cnt;
  logic [7:0] stb_q;
  logic ck_q;
  logic smp_seen;
  logic is_tmp;
  logic early;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // Low counters saturate so channels idle since reset never look early
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 8; i++)
        lo_cnt[i] <= LO;
      {stb_q, ck_q, smp_seen, is_tmp, hi_cnt, ck_cnt} <= '0;
    end else begin
      for (int i = 0; i < 8; i++)
        lo_cnt[i] <= strobe_o[i] ? 0 : (lo_cnt[i] < LO ? lo_cnt[i] + 1 : LO);
      stb_q <= strobe_o;
      ck_q <= adc_clk_o;
      ck_cnt <= (adc_clk_o != ck_q) ? 1 : ck_cnt + 1;
      hi_cnt <= (strobe_o != 0) ? hi_cnt + 1 : 0;
      smp_seen <= (strobe_o != 0) && (smp_seen || adc_sample_o);
      // Late sampling start marks a temperature channel
      is_tmp <= (strobe_o != 0) && (is_tmp || (!smp_seen && hi_cnt == 100));
    end
  end

  // A rising strobe whose channel has not rested long enough
  always_comb begin
    early = 1'b0;
    for (int i = 0; i < 8; i++)
      if (strobe_o[i] && !stb_q[i] && lo_cnt[i] < LO - 1)
        early = 1'b1;
  end

  a_strobe_onehot: assert property ($onehot0(strobe_o))
    else $error("more than one strobe high");
  a_start_in_chan: assert property (adc_start_o |-> $onehot(strobe_o))
    else $error("start without a strobe");
  a_no_switch: assert property (
    (strobe_o != 0) && ($past(strobe_o) != 0) |-> $stable(strobe_o))
    else $error("strobe moved without dropping");
  a_low_gap: assert property (!early)
    else $error("strobe raised inside low time");
  a_cur_high: assert property ($fell(|strobe_o) |-> hi_cnt >= HC)
    else $error("strobe high time too short");
  a_tmp_high: assert property (
    $fell(|strobe_o) && is_tmp |-> hi_cnt >= HT)
    else $error("temperature strobe too short");
  a_start_after_smp: assert property (
    $fell(adc_sample_o) |-> ##[0:1] adc_start_o)
    else $error("no start after sampling");
  a_smp_in_chan: assert property (adc_sample_o |-> strobe_o != 0)
    else $error("sampling without a strobe");
  a_adc_clk_rate: assert property (
    $changed(adc_clk_o) |-> ck_cnt inside {[14:512]})
    else $error("ADC clock half period out of range");
  a_turn_space: assert property (adc_start_o |=> !adc_start_o [*8])
    else $error("starts too close together");
  a_busy_strobe: assert property (strobe_o != 0 |-> busy_o)
    else $error("strobe high while not busy");
endmodule

bind adss_sequencer adss_sequencer_chk u_chk (.core_clk_i(core_clk_i),
  .nrst_i(nrst_i), .strobe_o(strobe_o), .adc_sample_o(adc_sample_o),
  .adc_start_o(adc_start_o), .adc_clk_o(adc_clk_o), .busy_o(busy_o));

// file: sim/adss_sequencer_tb_top.sv
// Self-checking testbench for the ADC strobe sequencer
`timescale 1ns/1ps
`include "adss_map.vh"

module adss_sequencer_tb_top;
  typedef struct packed {
    logic tmp; logic [2:0] ch; logic [7:0] stc; logic [7:0] dv; logic [11:0] v;
  } adss_row_t;
  // Channel, mode, timing setup and the result the converter hands back
  adss_row_t rows [4] = '{'{1'b0, 3'd0, 8'd0, 8'd0, 12'h5a1},
    '{1'b1, 3'd7, 8'd0, 8'd6, 12'h0ff}, '{1'b1, 3'd3, 8'd50, 8'd6, 12'ha3c},
    '{1'b0, 3'd5, 8'd20, 8'd9, 12'h7e2}};
  logic clk, nrst, awv, wv, bry, arv, rry, awr, wrdy, bv, arr, rv, done;
  logic samp, start, aclk, busy;
  logic [7:0] awa, ara, stb;
  logic [31:0] wd, rd, data;
  logic [1:0] br, rr, resp;
  logic [11:0] res, val;
  int err_count, n_checks, hi, st, sm, bad, sl;
  int cyc = 0;

  adss_sequencer uut (.core_clk_i(clk), .nrst_i(nrst),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .adc_done_i(done),
    .adc_result_i(res), .strobe_o(stb), .adc_sample_o(samp),
    .adc_start_o(start), .adc_clk_o(aclk), .busy_o(busy));
  adss_adc_model #(.CONV(30)) adc (.clk_i(clk), .nrst_i(nrst),
    .start_i(start), .sample_i(samp), .val_i(val), .done_o(done),
    .result_o(res));

  // ------------------------------------------------------------
  // Bus and checking tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Ready sampled at the rising edge; an edge passes between requests
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic hb;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wrdy) wv <= 0;
      hb = bv; resp = br;
      if (hb) bry <= 0;
    end while (!hb);
  endtask

  task automatic rdr(input logic [7:0] a);
    logic hr;
    @(posedge clk);
    ara <= a; arv <= 1; rry <= 1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      hr = rv; resp = rr; data = rd;
      if (hr) rry <= 0;
    end while (!hr);
  endtask

  // Measures one conversion until busy drops
  task automatic watch(input logic [7:0] e);
    int n;
    hi = 0; st = 0; sm = 0; bad = 0; n = 0;
    do begin
      @(negedge clk);
      n++;
      hi += (stb === e);
      st += (stb === e && sm == 0 && samp === 1'b0);
      sm += (samp === 1'b1);
      bad += (stb !== e && stb !== 8'h00);
    end while (!(n > 8 && busy === 1'b0));
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {nrst, awv, wv, bry, arv, rry, awa, ara, wd, val} = '0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    check({stb, busy}, 0);
    rdr(`ADSS_REG_CFG);
    check(data, `ADSS_CFG_RST);
    foreach (rows[i]) begin
      val <= rows[i].v;
      wr(`ADSS_REG_CFG, {16'h0, rows[i].dv, rows[i].stc});
      fork
        wr(`ADSS_REG_CTRL, {25'h0, rows[i].ch, 2'b00, rows[i].tmp, 1'b1});
        watch(8'h01 << rows[i].ch);
      join
      sl = (2 + rows[i].stc) * 4 * (1 + (rows[i].dv < 6 ? 6 : rows[i].dv));
      if (rows[i].tmp && sl < 1250)
        sl = 1250;
      check(sm, sl);
      check(hi >= (rows[i].tmp ? 2500 : 1250), 1);
      check(rows[i].tmp ? st >= 1250 : 1, 1);
      check(bad, 0);
      rdr(`ADSS_REG_RES);
      check(data[11:0], rows[i].v);
      rdr(`ADSS_REG_STAT);
      check(data[4], 1'b1);
    end
    // Channel 5 just fell: a new start must wait out its low time
    wr(`ADSS_REG_CTRL, 32'h0000_0051);
    repeat (20) @(posedge clk);
    check({stb, busy}, 0);
    repeat (1250) @(posedge clk);
    // A second start while busy must not steal the strobe
    fork
      wr(`ADSS_REG_CTRL, 32'h0000_0051);
      watch(8'h20);
      begin
        repeat (100) @(posedge clk);
        wr(`ADSS_REG_CTRL, 32'h0000_0021);
      end
    join
    check(bad, 0);
    check(hi >= 1250, 1);
    // Divider 9 gives a 40-cycle converter clock
    hi = 0;
    while (aclk !== 1'b0) @(negedge clk);
    while (aclk !== 1'b1) @(negedge clk);
    do begin @(negedge clk); hi++; end while (aclk !== 1'b0);
    while (aclk !== 1'b1) begin @(negedge clk); hi++; end
    check(hi, 40);
    // Reset in mid-conversion drops every output at once
    wr(`ADSS_REG_CTRL, 32'h0000_0003);
    repeat (30) @(posedge clk);
    check({stb, busy}, {8'h01, 1'b1});
    nrst <= 0;
    @(posedge clk);
    check({stb, busy, samp, start}, 0);
    nrst <= 1;
    // Unmapped word answers with an error
    rdr(8'h10);
    check(resp, `ADSS_RESP_ERR);
    check(data, 32'h0);
    wr(8'h10, 32'hffff_ffff);
    check(resp, `ADSS_RESP_ERR);
    tally_and_finish();
  end
endmodule
